// ===== shared/twu_pkg.sv
package twu_pkg;

	// ============================================================
	// Unlock key register and key sequence
	localparam logic [7:0] TWU_KEY_ADDR    = 8'hC7;
	localparam logic [7:0] TWU_KEY_FIRST   = 8'hAA;
	localparam logic [7:0] TWU_KEY_SECOND  = 8'h55;
	localparam logic [7:0] TWU_KEY_READ    = 8'h00;

	// ============================================================
	// Protected registers
	localparam logic [7:0] TWU_WDOG_ADDR   = 8'hD8;
	localparam logic [7:0] TWU_ROMSZ_ADDR  = 8'hC2;
	localparam logic [7:0] TWU_WAIT_ADDR   = 8'hC4;
	localparam logic [7:0] TWU_PWR_ADDR    = 8'hC6;

	localparam logic [7:0] TWU_WDOG_RESET  = 8'h00;
	localparam logic [7:0] TWU_ROMSZ_RESET = 8'h00;
	localparam logic [7:0] TWU_WAIT_RESET  = 8'h00;
	localparam logic [7:0] TWU_PWR_RESET   = 8'h00;
	localparam logic [7:0] TWU_UNMAPPED    = 8'h00;

	// Field positions
	localparam int unsigned TWU_WDOG_EN_BIT   = 1;
	localparam int unsigned TWU_PWR_POR_BIT   = 0;
	localparam int unsigned TWU_PWR_FAIL_BIT  = 1;

	// ============================================================
	// Timing, counted in machine cycles
	localparam int unsigned TWU_WINDOW_MC = 3;
	localparam int unsigned TWU_MC_W      = 2;

	typedef enum logic [1:0] {
		TWU_IDLE  = 2'b00,
		TWU_ARMED = 2'b01,
		TWU_OPEN  = 2'b11
	} twu_state_e;

endpackage

// ===== shared/twu_if.sv
`timescale 1ns/1ns
interface twu_if;
	logic       ce;
	logic       mc_tick;
	logic       key_wr;
	logic [7:0] key_data;
	logic       window_open;
	logic       armed;

	modport ctrl (
		output ce,
		output mc_tick,
		output key_wr,
		output key_data,
		input  window_open,
		input  armed
	);

	modport seq (
		input  ce,
		input  mc_tick,
		input  key_wr,
		input  key_data,
		output window_open,
		output armed
	);
endinterface

// ===== logic/twu_window.sv
`timescale 1ns/1ns
module twu_window #(
	parameter int unsigned WINDOW_MC = twu_pkg::TWU_WINDOW_MC
) (
	input  wire logic mclk_in,
	input  wire logic reset_in,
	twu_if.seq        tw
);
	import twu_pkg::*;

	localparam logic [TWU_MC_W-1:0] LAST_MC = TWU_MC_W'(WINDOW_MC);

	twu_state_e          state;
	logic [TWU_MC_W-1:0] elapsed;

	// ============================================================
	// Key sequence and window timer
	// A key write wins over a machine-cycle tick in the same clock,
	// since the write belongs to the instruction that ends there.
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			state   <= TWU_IDLE;
			elapsed <= '0;
		end else if (tw.ce) begin
			if (tw.key_wr) begin
				elapsed <= '0;
				if (tw.key_data == TWU_KEY_FIRST) begin
					state <= TWU_ARMED;
				end else if (tw.key_data == TWU_KEY_SECOND && state == TWU_ARMED) begin
					state <= TWU_OPEN;
				end else begin
					state <= TWU_IDLE;
				end
			end else if (tw.mc_tick && state != TWU_IDLE) begin
				if (elapsed == LAST_MC) begin
					state   <= TWU_IDLE;
					elapsed <= '0;
				end else begin
					elapsed <= elapsed + 1'b1;
				end
			end
		end
	end

	assign tw.window_open = (state == TWU_OPEN);
	assign tw.armed       = (state == TWU_ARMED);

endmodule

// ===== logic/twu_top.sv
`timescale 1ns/1ns
module twu_top #(
	parameter int unsigned WINDOW_MC = twu_pkg::TWU_WINDOW_MC
) (
	input  wire logic       mclk_in,
	input  wire logic       reset_in,
	input  wire logic       ce_in,
	input  wire logic       mc_tick_in,
	input  wire logic       sfr_wr_in,
	input  wire logic       sfr_rd_in,
	input  wire logic [7:0] sfr_addr_in,
	input  wire logic [7:0] sfr_wdata_in,
	input  wire logic       por_event_in,
	input  wire logic       pfail_event_in,
	output logic      [7:0] sfr_rdata_out,
	output logic      [7:0] watchdog_control_out,
	output logic      [7:0] rom_size_out,
	output logic      [7:0] wait_state_out,
	output logic      [7:0] power_flag_out,
	output logic            watchdog_enable_out,
	output logic            window_open_out,
	output logic            key_armed_out,
	output logic            protect_drop_out
);
	import twu_pkg::*;

	// ============================================================
	// Key sequence timer
	twu_if tw ();

	assign tw.ce       = ce_in;
	assign tw.mc_tick  = mc_tick_in;
	assign tw.key_wr   = sfr_wr_in && (sfr_addr_in == TWU_KEY_ADDR);
	assign tw.key_data = sfr_wdata_in;

	twu_window #(
		.WINDOW_MC (WINDOW_MC)
	) u_window (
		.mclk_in  (mclk_in),
		.reset_in (reset_in),
		.tw       (tw)
	);

	// ============================================================
	// Address decode
	logic hit_wdog;
	logic hit_romsz;
	logic hit_wait;
	logic hit_pwr;
	logic hit_prot;
	logic wr_prot;
	logic wr_allowed;
	logic wr_dropped;

	always_comb begin
		hit_wdog  = (sfr_addr_in == TWU_WDOG_ADDR);
		hit_romsz = (sfr_addr_in == TWU_ROMSZ_ADDR);
		hit_wait  = (sfr_addr_in == TWU_WAIT_ADDR);
		hit_pwr   = (sfr_addr_in == TWU_PWR_ADDR);
		hit_prot  = hit_wdog || hit_romsz || hit_wait || hit_pwr;
	end

	// Gate is the window as seen in the same clock as the write, so a write
	// landing on the last open cycle still counts.
	always_comb begin
		wr_prot    = sfr_wr_in && hit_prot;
		wr_allowed = wr_prot && tw.window_open;
		wr_dropped = wr_prot && !tw.window_open;
	end

	// ============================================================
	// Watchdog control
	logic [7:0] watchdog_control_reg;

	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			watchdog_control_reg <= TWU_WDOG_RESET;
		end else if (ce_in) begin
			if (wr_allowed && hit_wdog) begin
				watchdog_control_reg <= sfr_wdata_in;
			end
		end
	end

	// ============================================================
	// ROM size adjustment
	logic [7:0] rom_size_reg;

	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			rom_size_reg <= TWU_ROMSZ_RESET;
		end else if (ce_in) begin
			if (wr_allowed && hit_romsz) begin
				rom_size_reg <= sfr_wdata_in;
			end
		end
	end

	// ============================================================
	// Wait-state control
	logic [7:0] wait_state_reg;

	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			wait_state_reg <= TWU_WAIT_RESET;
		end else if (ce_in) begin
			if (wr_allowed && hit_wait) begin
				wait_state_reg <= sfr_wdata_in;
			end
		end
	end

	// ============================================================
	// Power-on and power-fail flags
	// Hardware sets the flags; software may clear or write them only through
	// the window. A set arriving with a software clear wins, so no event is lost.
	logic [7:0] power_flag_reg;
	logic [7:0] pwr_set;
	logic [7:0] pwr_next;

	always_comb begin
		pwr_set                   = '0;
		pwr_set[TWU_PWR_POR_BIT]  = por_event_in;
		pwr_set[TWU_PWR_FAIL_BIT] = pfail_event_in;
		pwr_next                  = power_flag_reg;
		if (wr_allowed && hit_pwr) begin
			pwr_next = sfr_wdata_in;
		end
		pwr_next = pwr_next | pwr_set;
	end

	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			power_flag_reg <= TWU_PWR_RESET;
		end else if (ce_in) begin
			power_flag_reg <= pwr_next;
		end
	end

	// ============================================================
	// Read port
	logic [7:0] rd_mux;

	always_comb begin
		case (sfr_addr_in)
			TWU_WDOG_ADDR:  rd_mux = watchdog_control_reg;
			TWU_ROMSZ_ADDR: rd_mux = rom_size_reg;
			TWU_WAIT_ADDR:  rd_mux = wait_state_reg;
			TWU_PWR_ADDR:   rd_mux = power_flag_reg;
			TWU_KEY_ADDR:   rd_mux = TWU_KEY_READ;
			default:        rd_mux = TWU_UNMAPPED;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			sfr_rdata_out <= TWU_UNMAPPED;
		end else if (ce_in) begin
			if (sfr_rd_in) begin
				sfr_rdata_out <= rd_mux;
			end
		end
	end

	// ============================================================
	// Control outputs
	// Registered copies lag the stored value by one clock; the protected
	// state itself never depends on these outputs.
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			watchdog_control_out <= TWU_WDOG_RESET;
			rom_size_out         <= TWU_ROMSZ_RESET;
			wait_state_out       <= TWU_WAIT_RESET;
			power_flag_out       <= TWU_PWR_RESET;
			watchdog_enable_out  <= TWU_WDOG_RESET[TWU_WDOG_EN_BIT];
		end else if (ce_in) begin
			watchdog_control_out <= watchdog_control_reg;
			rom_size_out         <= rom_size_reg;
			wait_state_out       <= wait_state_reg;
			power_flag_out       <= power_flag_reg;
			watchdog_enable_out  <= watchdog_control_reg[TWU_WDOG_EN_BIT];
		end
	end

	// ============================================================
	// Window status and drop indication
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			window_open_out  <= 1'b0;
			key_armed_out    <= 1'b0;
			protect_drop_out <= 1'b0;
		end else if (ce_in) begin
			window_open_out  <= tw.window_open;
			key_armed_out    <= tw.armed;
			protect_drop_out <= wr_dropped;
		end
	end

endmodule

// ===== tb/twu_top_asserts.sv
`timescale 1ns/1ns
module twu_top_asserts import twu_pkg::*; #(
	parameter int unsigned WINDOW_MC = 3
) (
	input wire logic       mclk_in,
	input wire logic       reset_in,
	input wire logic       ce_in,
	input wire logic       mc_tick_in,
	input wire logic       sfr_wr_in,
	input wire logic       sfr_rd_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic [7:0] sfr_rdata_out,
	input wire logic [7:0] watchdog_control_out,
	input wire logic       window_open_out,
	input wire logic       key_armed_out,
	input wire logic       protect_drop_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (reset_in);
	wire        wr   = ce_in && sfr_wr_in;
	wire        kw   = wr && sfr_addr_in == TWU_KEY_ADDR;
	wire        k55  = kw && sfr_wdata_in == TWU_KEY_SECOND;
	wire        prot = sfr_addr_in inside {TWU_WDOG_ADDR, TWU_ROMSZ_ADDR, TWU_WAIT_ADDR, TWU_PWR_ADDR};
	logic [3:0] open_ticks;
	// Slack of one tick: the window output lags the state by a clock
	always_ff @(posedge mclk_in) begin
		if (reset_in || !window_open_out) open_ticks <= 4'h0;
		else if (ce_in && mc_tick_in) open_ticks <= open_ticks + 4'h1;
	end
	// ============================================================
	// Assertions
	drop_cause_a: assert property (protect_drop_out |-> $past(wr && prot))
		else $error("drop pulse without a protected write");
	wdog_guard_a: assert property ($changed(watchdog_control_out) |-> $past(wr && sfr_addr_in == TWU_WDOG_ADDR, 2))
		else $error("watchdog control changed without a write");
	reset_idle_a: assert property (disable iff (1'b0) reset_in && ce_in |=> !window_open_out && !key_armed_out)
		else $error("window or arming active after reset");
	arm_key_a: assert property (kw && sfr_wdata_in == TWU_KEY_FIRST |-> ##[1:2] key_armed_out)
		else $error("first key did not arm");
	open_cause_a: assert property ($rose(window_open_out) |-> $past(k55) || $past(k55, 2))
		else $error("window opened without second key");
	open_bound_a: assert property (open_ticks <= WINDOW_MC + 2)
		else $error("window stayed open too long");
	key_read_a: assert property (ce_in && sfr_rd_in && sfr_addr_in == TWU_KEY_ADDR |=> sfr_rdata_out == TWU_KEY_READ)
		else $error("key register read not zero");
	accept_wr_a: assert property (k55 && key_armed_out && !mc_tick_in && !$past(mc_tick_in) && !$past(kw)
		##1 (!mc_tick_in && !wr)[*2] ##1 (wr && sfr_addr_in == TWU_WDOG_ADDR)
		|-> ##2 watchdog_control_out == $past(sfr_wdata_in, 2)) else $error("write in open window lost");
	cover property (k55);
	cover property ($rose(window_open_out));
	cover property (protect_drop_out);
endmodule
bind twu_top twu_top_asserts #(.WINDOW_MC(WINDOW_MC)) u_chk (.mclk_in, .reset_in, .ce_in, .mc_tick_in, .sfr_wr_in,
	.sfr_rd_in, .sfr_addr_in, .sfr_wdata_in, .sfr_rdata_out, .watchdog_control_out, .window_open_out,
	.key_armed_out, .protect_drop_out);

// ===== tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	import twu_pkg::*;
	logic       mclk_in = 1'h0, reset_in = 1'h1, mc_tick_in = 1'h0, sfr_wr_in = 1'h0, sfr_rd_in = 1'h0;
	logic [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, rdata, wdog, rom;
	logic       wdog_en, win, armed, drop, drop_seen = 1'h0, por = 1'h0;
	logic [7:0] wst, pwr;
	logic [7:0] pa [4] = '{8'hD8, 8'hC2, 8'hC4, 8'hC6};
	logic [7:0] pd [4] = '{8'h02, 8'h5A, 8'hA5, 8'h3C};
	int         bad_count = 0, cmp_count = 0;
	// Power-fail event tied low; the power-on event is pulsed once near the end
	twu_top #(.WINDOW_MC(3)) uut (.mclk_in, .reset_in, .ce_in(1'h1), .mc_tick_in, .sfr_wr_in, .sfr_rd_in,
		.sfr_addr_in, .sfr_wdata_in, .por_event_in(por), .pfail_event_in(1'h0), .sfr_rdata_out(rdata),
		.watchdog_control_out(wdog), .rom_size_out(rom), .wait_state_out(wst), .power_flag_out(pwr),
		.watchdog_enable_out(wdog_en), .window_open_out(win), .key_armed_out(armed), .protect_drop_out(drop));
	initial forever #25 mclk_in = ~mclk_in;
	always @(posedge mclk_in) if (drop === 1'h1) drop_seen <= 1'h1;
	// ============================================================
	// Bus tasks
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	// Strobes drop here so back-to-back accesses never toggle them in one step
	task automatic cyc(input int n);
		sfr_wr_in = 1'h0;
		sfr_rd_in = 1'h0;
		repeat (n) @(negedge mclk_in);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_rd_in = 1'h0;
		sfr_addr_in = a;
		sfr_wdata_in = d;
		sfr_wr_in = 1'h1;
		@(negedge mclk_in);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		sfr_wr_in = 1'h0;
		sfr_addr_in = a;
		sfr_rd_in = 1'h1;
		@(negedge mclk_in);
		chk("read data", rdata, e);
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			mc_tick_in = 1'h1;
			cyc(1);
			mc_tick_in = 1'h0;
			cyc(1);
		end
	endtask
	task automatic unlock(input int gap);
		wr(TWU_KEY_ADDR, TWU_KEY_FIRST);
		cyc(1);
		chk("armed", {7'h0, armed}, 8'h01);
		tick(gap);
		wr(TWU_KEY_ADDR, TWU_KEY_SECOND);
		cyc(1);
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ============================================================
	// Tests
	initial begin
		cyc(8);
		reset_in = 1'h0;
		cyc(1);
		chk("window", {7'h0, win}, 8'h00);
		wr(TWU_WDOG_ADDR, 8'h02);
		cyc(2);
		chk("dropped", {7'h0, drop_seen}, 8'h01);
		chk("watchdog", wdog, TWU_WDOG_RESET);
		unlock(3);
		chk("window", {7'h0, win}, 8'h01);
		foreach (pa[i]) wr(pa[i], pd[i]);
		cyc(2);
		chk("enable", {7'h0, wdog_en}, 8'h01);
		chk("wait state", wst, 8'hA5);
		chk("power flags", pwr, 8'h3C);
		foreach (pa[i]) rd(pa[i], pd[i]);
		rd(TWU_KEY_ADDR, TWU_KEY_READ);
		rd(8'h10, TWU_UNMAPPED);
		tick(3);
		chk("window", {7'h0, win}, 8'h01);
		tick(1);
		chk("window", {7'h0, win}, 8'h00);
		drop_seen = 1'h0;
		wr(TWU_WDOG_ADDR, 8'h00);
		cyc(2);
		chk("watchdog", wdog, 8'h02);
		chk("dropped", {7'h0, drop_seen}, 8'h01);
		unlock(4);
		chk("window", {7'h0, win}, 8'h00);
		wr(TWU_ROMSZ_ADDR, 8'hFF);
		cyc(2);
		chk("rom size", rom, 8'h5A);
		wr(TWU_KEY_ADDR, TWU_KEY_SECOND);
		cyc(2);
		chk("window", {7'h0, win}, 8'h00);
		unlock(0);
		cyc(1);
		wr(TWU_WDOG_ADDR, 8'h00);
		cyc(2);
		chk("watchdog", wdog, 8'h00);
		por = 1'h1;
		cyc(1);
		por = 1'h0;
		cyc(2);
		chk("power flags", pwr, 8'h3D);
		rd(TWU_PWR_ADDR, 8'h3D);
		finish_test();
	end
	initial begin
		#50000;
		bad_count++;
		finish_test();
	end
endmodule
